// *** verilog/interval_counter_pkg.sv ***
// Package holding register map, field layout and encodings of the serial interval counter.
package interval_counter_pkg;

	// ----------------------------------------------------------------
	// Register indices; the byte address is four times the index.
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_COUNTER_CONTROL = 8'h42; // Control register index.
	localparam logic [7:0] IDX_COUNTER_PRELOAD = 8'h43; // Preload register index.
	localparam logic [7:0] IDX_COUNTER_VALUE   = 8'h44; // Counter register index.
	localparam logic [7:0] IDX_RECEIVE_QUEUE   = 8'h45; // Received-bit queue index.

	// ----------------------------------------------------------------
	// Control register fields.
	// ----------------------------------------------------------------
	localparam int CTL_SRC_LO   = 0; // Clock source select, low bit.
	localparam int CTL_SRC_HI   = 1; // Clock source select, high bit.
	localparam int CTL_ENABLE   = 2; // Count enable.
	localparam int CTL_START    = 3; // Start-bit edge detection on.
	localparam int CTL_TX_BIT   = 4; // Next bit to transmit.
	localparam int CTL_TX_OE    = 5; // Drive the serial output pin.
	localparam int CTL_RX_LATCH = 6; // Receive latch, read only.
	localparam int CTL_CAPTURE  = 7; // Push sampled bits into the queue.

	localparam logic [7:0] CTL_RESET      = 8'h00; // Control value after reset.
	localparam logic [7:0] CTL_WRITE_MASK = 8'hbf; // Bits software may write.
	localparam logic [7:0] PRELOAD_RESET  = 8'h00; // Preload value after reset.
	localparam logic [7:0] COUNT_RESET    = 8'h00; // Counter value after reset.
	localparam logic [7:0] COUNT_TOP      = 8'hff; // Last value before wrap.
	localparam logic [7:0] COUNT_STEP     = 8'h01; // Increment per tick.

	// ----------------------------------------------------------------
	// Queue read layout and bus answers.
	// ----------------------------------------------------------------
	localparam int QUEUE_BIT   = 0; // Oldest received bit.
	localparam int QUEUE_VALID = 1; // Oldest bit is present.
	localparam logic [1:0] RESP_OKAY   = 2'h0; // Normal answer.
	localparam logic [1:0] RESP_SLVERR = 2'h2; // Unmapped address.

	// Counter clock sources.
	typedef enum logic [1:0] {
		SRC_MAIN,
		SRC_AUX,
		SRC_PIN,
		SRC_GATED
	} clk_src_t;

	// Start-bit detection phase.
	typedef enum logic {
		PHASE_WAIT,
		PHASE_RUN
	} phase_t;

endpackage

// *** verilog/bit_queue_if.sv ***
// Interface carrying the filling and draining handshakes of the received-bit queue.
`timescale 1ns/10ps
`default_nettype none
interface bit_queue_if #(
	parameter int WIDTH = 1
);
	logic             in_valid;  // Filling side offers a word.
	logic             in_ready;  // Queue can take a word.
	logic [WIDTH-1:0] in_data;   // Word offered.
	logic             out_valid; // Queue holds a word.
	logic             out_ready; // Draining side takes the word.
	logic [WIDTH-1:0] out_data;  // Oldest word, registered.

	modport filler (output in_valid, output in_data, input in_ready,
		input out_valid, input out_data, output out_ready);
	modport store (input in_valid, input in_data, output in_ready,
		output out_valid, output out_data, input out_ready);
endinterface
`default_nettype wire

// *** verilog/bit_queue.sv ***
// Small FIFO buffering received bits between the counter and the register bus.
`timescale 1ns/10ps
`default_nettype none
module bit_queue #(
	parameter int WIDTH = 1,
	parameter int DEPTH = 8
) (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic ce,
	bit_queue_if.store q
);
	localparam int PW = $clog2(DEPTH);

	// ----------------------------------------------------------------
	// State.
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;  // Storage words.
		logic [PW-1:0]               wr;   // Write pointer.
		logic [PW-1:0]               rd;   // Read pointer.
		logic [PW:0]                 fill; // Words held.
		logic [WIDTH-1:0]            head; // Registered oldest word.
	} queue_t;

	queue_t s;      // Current state.
	queue_t next_s; // Next state.

	// Pointer step with wrap at the depth, since depth need not be a power of two.
	function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
		return (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
	endfunction

	// Full and empty are taken from the registered fill count, so both are honest.
	assign q.in_ready  = (s.fill != (PW+1)'(DEPTH));
	assign q.out_valid = (s.fill != '0);
	assign q.out_data  = s.head;

	// Push and pop may happen together; the head follows the read pointer.
	always_comb begin
		next_s = s;
		if (q.in_valid && q.in_ready) begin
			next_s.mem[s.wr] = q.in_data;
			next_s.wr        = step(s.wr);
		end
		if (q.out_valid && q.out_ready) begin
			next_s.rd = step(s.rd);
		end
		next_s.fill = (PW+1)'(s.fill + (PW+1)'(q.in_valid && q.in_ready)
			- (PW+1)'(q.out_valid && q.out_ready));
		next_s.head = next_s.mem[next_s.rd];
	end

	// Register the whole state; the clock enable freezes it.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
		end else if (ce) begin
			s <= next_s;
		end
	end
endmodule
`default_nettype wire

// *** verilog/serial_interval_counter.sv ***
// Eight-bit interval counter with preload, clock selector, start-bit detection and bit latches.
`timescale 1ns/10ps
`default_nettype none

module serial_interval_counter
	import interval_counter_pkg::*;
#(
	parameter int ADDR_W      = 12,
	parameter int QUEUE_DEPTH = 8
) (
	// Clock, reset and clock enable.
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              ce,

	// Write channels.
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output var  logic              s_axi_awready,

	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output var  logic              s_axi_wready,
	output var  logic [1:0]        s_axi_bresp,
	output var  logic              s_axi_bvalid,
	input  wire logic              s_axi_bready,

	// Read channels.
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output var  logic              s_axi_arready,
	output var  logic [31:0]       s_axi_rdata,
	output var  logic [1:0]        s_axi_rresp,
	output var  logic              s_axi_rvalid,
	input  wire logic              s_axi_rready,

	// Clock sources and far-side pins.
	input  wire logic              aux_clock,
	input  wire logic              shared_port_pin_one,
	output var  logic              shared_port_pin_two,
	output var  logic              shared_port_pin_two_oe,
	output var  logic              interval_done
);

	// ----------------------------------------------------------------
	// State of the block.
	// ----------------------------------------------------------------
	typedef struct packed {
		// Bus side.
		logic              aw_held;   // Write address taken, waiting for data.
		logic [ADDR_W-1:0] aw_addr;   // Held write address.
		logic              w_held;    // Write data taken, waiting for address.
		logic [31:0]       w_data;    // Held write data.
		logic [3:0]        w_strb;    // Held byte enables.

		logic              bvalid;    // Write answer pending.
		logic [1:0]        bresp;     // Write answer code.

		logic              rvalid;    // Read answer pending.
		logic [31:0]       rdata;     // Read answer data.
		logic [1:0]        rresp;     // Read answer code.
		logic              arready;   // Read address channel open.

		// Counter side.
		logic [7:0]        ctl;       // Control register.
		logic [7:0]        preload;   // Preload register.
		logic [7:0]        count;     // The counter itself.

		phase_t            phase;     // Start-bit detection phase.
		logic              rx_latch;  // Receive data latch.
		logic              tx_latch;  // Transmit data latch.

		logic              aux_prev;  // Auxiliary clock one cycle ago.
		logic              pin_prev;  // Pin one one cycle ago.
		logic              carry;     // Carry-out pulse.
	} state_t;

	state_t s;      // Current state.
	state_t next_s; // Next state.

	bit_queue_if #(.WIDTH(1)) rxq (); // Received-bit queue handshakes.

	// ----------------------------------------------------------------
	// Helpers.
	// ----------------------------------------------------------------

	// True when a byte address selects the register of the given index.
	// The index counts words, so two zero bits follow it.
	function automatic logic reg_hit(
		input logic [ADDR_W-1:0] addr,
		input logic [7:0]        idx
	);
		return addr == ADDR_W'({idx, 2'b00});
	endfunction

	// True when the address selects any mapped register.
	function automatic logic mapped(input logic [ADDR_W-1:0] addr);
		return reg_hit(addr, IDX_COUNTER_CONTROL)
			|| reg_hit(addr, IDX_COUNTER_PRELOAD)
			|| reg_hit(addr, IDX_COUNTER_VALUE)
			|| reg_hit(addr, IDX_RECEIVE_QUEUE);
	endfunction

	// ----------------------------------------------------------------
	// Counter control signals.
	// ----------------------------------------------------------------
	logic     tick;        // One counting edge of the selected clock.
	logic     stall;       // Queue full while capturing.

	logic     count_en;    // Enable input of the counter.
	logic     load;        // Load input of the counter.
	logic     wrap;        // Counter passes all ones on this tick.
	logic     start_edge;  // Falling edge on the receive input.

	// Bus strobes.
	logic     do_write;    // Address and data both held.
	logic     do_read;     // Read address taken this cycle.

	clk_src_t src;         // Decoded clock source.

	// Select the counting event; the inputs are synchronous, so one register suffices.
	always_comb begin
		src = clk_src_t'(s.ctl[CTL_SRC_HI:CTL_SRC_LO]);
		case (src)
			SRC_MAIN: begin
				// Every enabled cycle counts.
				tick = 1'b1;
			end

			SRC_AUX: begin
				// The auxiliary clock is slower than ours, so its rising edge is seen once.
				tick = aux_clock && !s.aux_prev;
			end

			SRC_PIN: begin
				// Pin one used as an external clock input.
				tick = shared_port_pin_one && !s.pin_prev;
			end

			SRC_GATED: begin
				// Main clock passed only while pin one is high.
				tick = shared_port_pin_one;
			end
			default: begin
				tick = 1'b0;
			end
		endcase
	end

	// A full queue halts counting, so no sampled bit is ever dropped.
	assign stall      = s.ctl[CTL_CAPTURE]
		&& !rxq.in_ready;
	assign start_edge = s.pin_prev && !shared_port_pin_one;
	assign count_en   = s.ctl[CTL_ENABLE]
		&& (s.phase == PHASE_RUN)
		&& !stall;
	assign wrap       = count_en && tick
		&& (s.count == COUNT_TOP);

	// Bus decodes.
	assign do_write   = s.aw_held && s.w_held && !s.bvalid;
	assign do_read    = s_axi_arvalid && s.arready;
	assign load       = do_write && reg_hit(s.aw_addr, IDX_COUNTER_VALUE)
		&& s.w_strb[0];

	// Sampled bits go to the queue on the carry, and are popped by reading it.
	assign rxq.in_valid  = s.ctl[CTL_CAPTURE] && wrap;
	assign rxq.in_data   = shared_port_pin_one;
	assign rxq.out_ready = do_read
		&& reg_hit(s_axi_araddr, IDX_RECEIVE_QUEUE);

	// ----------------------------------------------------------------
	// Next-state logic.
	// ----------------------------------------------------------------
	always_comb begin
		next_s = s;
		// Edge history and the one-cycle carry.
		next_s.aux_prev = aux_clock;
		next_s.pin_prev = shared_port_pin_one;
		next_s.carry    = 1'b0;

		// Write address and data are taken in either order and held.
		if (s_axi_awvalid && !s.aw_held) begin
			next_s.aw_held = 1'b1;
			next_s.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !s.w_held) begin
			next_s.w_held = 1'b1;
			next_s.w_data = s_axi_wdata;
			next_s.w_strb = s_axi_wstrb;
		end

		// Start detection waits for the edge before the counter may run.
		if (s.ctl[CTL_START] && s.phase == PHASE_WAIT
			&& start_edge) begin
			next_s.phase = PHASE_RUN;
		end

		// Counting; the counter holds whenever enable is low.
		if (count_en && tick) begin
			next_s.count = s.count + COUNT_STEP;
		end

		// End of interval: both latches are clocked by the carry.
		if (wrap) begin
			next_s.carry    = 1'b1;
			next_s.rx_latch = shared_port_pin_one;
			next_s.tx_latch = s.ctl[CTL_TX_BIT];
		end

		// Register writes once both halves are held.
		if (do_write) begin
			next_s.aw_held = 1'b0;
			next_s.w_held  = 1'b0;
			next_s.bvalid  = 1'b1;
			next_s.bresp   = mapped(s.aw_addr)
				? RESP_OKAY : RESP_SLVERR;

			// Upper byte lanes are ignored.
			if (s.w_strb[0]) begin
				if (reg_hit(s.aw_addr, IDX_COUNTER_CONTROL)) begin
					next_s.ctl = (s.w_data[7:0] & CTL_WRITE_MASK)
						| (s.ctl & ~CTL_WRITE_MASK);
					// Setting the start bit re-arms the detector for a new frame.
					next_s.phase = s.w_data[CTL_START]
						? PHASE_WAIT : PHASE_RUN;
				end else if (reg_hit(s.aw_addr, IDX_COUNTER_PRELOAD)) begin
					// The preload may be rewritten two cycles after a load, at the earliest.
					next_s.preload = s.w_data[7:0];
				end
			end
		end

		// A load wins over a count in the same cycle; written data are dropped.
		if (load) begin
			next_s.count = s.preload;
		end

		// Keep the receive latch visible in the control register.
		// Software reads the last sampled level there.
		next_s.ctl[CTL_RX_LATCH] = next_s.rx_latch;

		// Write answer leaves once the master takes it.
		if (s.bvalid && s_axi_bready) begin
			next_s.bvalid = 1'b0;
		end

		// Reads: the answer is registered one cycle after the address is taken.
		if (do_read) begin
			next_s.arready = 1'b0;
			next_s.rvalid  = 1'b1;
			next_s.rresp   = mapped(s_axi_araddr)
				? RESP_OKAY : RESP_SLVERR;
			// Unmapped reads return zero.
			next_s.rdata   = 32'h0000_0000;

			if (reg_hit(s_axi_araddr, IDX_COUNTER_CONTROL)) begin
				next_s.rdata[7:0] = s.ctl;
			end else if (reg_hit(s_axi_araddr, IDX_COUNTER_PRELOAD)) begin
				next_s.rdata[7:0] = s.preload;
			end else if (reg_hit(s_axi_araddr, IDX_COUNTER_VALUE)) begin
				next_s.rdata[7:0] = s.count;
			end else if (reg_hit(s_axi_araddr, IDX_RECEIVE_QUEUE)) begin
				next_s.rdata[QUEUE_BIT]   = rxq.out_data[0];
				next_s.rdata[QUEUE_VALID] = rxq.out_valid;
			end
		end

		// Reopen reads once answered.
		if (s.rvalid && s_axi_rready) begin
			next_s.rvalid  = 1'b0;
			next_s.arready = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// State register.
	// ----------------------------------------------------------------

	// Synchronous reset; the clock enable freezes everything while low.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s         <= '0;
			s.arready <= 1'b1;
			s.ctl     <= CTL_RESET;
			s.preload <= PRELOAD_RESET;
			s.count   <= COUNT_RESET;
			s.phase   <= PHASE_RUN;
			// The queue resets itself on the same input.
		end else if (ce) begin
			s <= next_s;
		end
	end

	// ----------------------------------------------------------------
	// Received-bit queue.
	// ----------------------------------------------------------------
	// A full queue stalls the counter rather than drop bits.
	bit_queue #(
		.WIDTH (1),
		.DEPTH (QUEUE_DEPTH)
	) u_rx_queue (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ce      (ce),
		.q       (rxq)
	);

	// ----------------------------------------------------------------
	// Outputs, all straight from the state register.
	// ----------------------------------------------------------------
	assign s_axi_awready          = !s.aw_held;
	assign s_axi_wready           = !s.w_held;

	assign s_axi_bvalid           = s.bvalid;
	assign s_axi_bresp            = s.bresp;

	assign s_axi_arready          = s.arready;

	assign s_axi_rvalid           = s.rvalid;
	assign s_axi_rdata            = s.rdata;
	assign s_axi_rresp            = s.rresp;

	// Pin two is driven only while the CTL_TX_OE bit is set.
	assign shared_port_pin_two    = s.tx_latch;
	assign shared_port_pin_two_oe = s.ctl[CTL_TX_OE];
	assign interval_done          = s.carry;

endmodule
`default_nettype wire

// *** sim/serial_peer.sv ***
// Far-side serial device that drives the receive line with timed low pulses.
`timescale 1ns/10ps
`default_nettype none
module serial_peer (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       go,
	input  wire logic [7:0] low_len,
	output var  logic       line
);
	logic [7:0] left; // Low cycles still to send.

	// ----------------------------------------------------------------
	// Line driver
	// ----------------------------------------------------------------
	// The line idles high, so every pulse starts with a falling edge.
	always @(posedge aclk) begin
		if (!aresetn || (left == 8'h1 && !go)) begin
			line <= 1'b1;
			left <= 8'h0;
		end else if (go) begin
			line <= 1'b0;
			left <= low_len;
		end else if (left != 8'h0) begin
			left <= left - 8'h1;
		end
	end
endmodule
`default_nettype wire

// *** sim/interval_counter_properties.sv ***
// Checker of bus answers and interval timing at the counter's ports.
`timescale 1ns/10ps
`default_nettype none
module interval_counter_properties
	import interval_counter_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	input wire logic              aclk,
	input wire logic              aresetn,
	input wire logic              s_axi_awvalid,
	input wire logic              s_axi_awready,
	input wire logic              s_axi_wvalid,
	input wire logic              s_axi_wready,
	input wire logic              s_axi_bvalid,
	input wire logic              s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic              s_axi_arvalid,
	input wire logic              s_axi_arready,
	input wire logic [31:0]       s_axi_rdata,
	input wire logic [1:0]        s_axi_rresp,
	input wire logic              s_axi_rvalid,
	input wire logic              s_axi_rready,
	input wire logic              shared_port_pin_two,
	input wire logic              interval_done
);
	// ----------------------------------------------------------------
	// Helper logic
	// ----------------------------------------------------------------
	logic ar_hit;   // Read address taken this cycle.
	logic mapped;   // Read address names one of the four registers.
	logic want_err; // Pending read must be refused.
	logic known;    // Pending read was aligned, so its answer is fixed.
	assign ar_hit = s_axi_arvalid && s_axi_arready;
	assign mapped = s_axi_araddr[ADDR_W-1:2] >= (ADDR_W-2)'(IDX_COUNTER_CONTROL)
		&& s_axi_araddr[ADDR_W-1:2] <= (ADDR_W-2)'(IDX_RECEIVE_QUEUE);

	// Remember what the read just taken must answer.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			want_err <= 1'b0;
			known <= 1'b0;
		end else if (ar_hit) begin
			want_err <= !mapped;
			known <= s_axi_araddr[1:0] == 2'h0;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	done_one_cycle_a: assert property (interval_done |=> !interval_done)
		else $error("interval end pulse too long");
	tx_on_carry_a: assert property ($changed(shared_port_pin_two) |-> interval_done)
		else $error("transmit pin moved without interval end");
	write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|=> !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid) else $error("write answer late");
	bvalid_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer repeated");
	read_answer_a: assert property (ar_hit |-> ##[1:2] s_axi_rvalid)
		else $error("read answer late");
	read_busy_a: assert property (ar_hit |=> !s_axi_arready)
		else $error("second read accepted");
	read_code_a: assert property (s_axi_rvalid && known |-> s_axi_rresp == (want_err ? RESP_SLVERR : RESP_OKAY)
		&& (!want_err || s_axi_rdata == 32'h0)) else $error("read answer code wrong");
	rvalid_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer repeated");
	reset_quiet_a: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid
		&& !interval_done && !shared_port_pin_two && s_axi_arready) else $error("outputs busy after reset");

	cover property (interval_done);
	cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
	cover property ($rose(shared_port_pin_two));
endmodule

bind serial_interval_counter interval_counter_properties #(.ADDR_W(ADDR_W)) props_inst (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.shared_port_pin_two(shared_port_pin_two), .interval_done(interval_done));
`default_nettype wire

// *** sim/tb.sv ***
// Self-checking testbench of the serial interval counter.
`timescale 1ns/10ps
`default_nettype none
module tb import interval_counter_pkg::*; ;
	localparam logic [11:0] A_CTL = {2'h0, IDX_COUNTER_CONTROL, 2'h0}; // Control.
	localparam logic [11:0] A_PRE = {2'h0, IDX_COUNTER_PRELOAD, 2'h0}; // Preload.
	localparam logic [11:0] A_CNT = {2'h0, IDX_COUNTER_VALUE, 2'h0};   // Counter.
	localparam logic [11:0] A_Q   = {2'h0, IDX_RECEIVE_QUEUE, 2'h0};   // Bit queue.

	logic        aclk, aresetn, ce, aux_clock, pin_one, pin_two, pin_two_oe, interval_done;
	logic [11:0] awaddr, araddr;                 // Bus addresses.
	logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata, seen, held;       // Bus data and last value read.
	logic [3:0]  wstrb;                          // Byte lanes.
	logic [1:0]  bresp, rresp;                   // Answer codes.
	logic        peer_go;                        // Starts one low pulse of the peer.
	logic [7:0]  peer_len;                       // Length of that pulse.
	int          n_errors, total_checks;         // Report counters.

	serial_interval_counter #(.ADDR_W(12), .QUEUE_DEPTH(8)) serial_interval_counter_inst (.aclk(aclk),
		.aresetn(aresetn), .ce(ce), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .aux_clock(aux_clock), .shared_port_pin_one(pin_one),
		.shared_port_pin_two(pin_two), .shared_port_pin_two_oe(pin_two_oe), .interval_done(interval_done));
	serial_peer serial_peer_inst (.aclk(aclk), .aresetn(aresetn), .go(peer_go), .low_len(peer_len),
		.line(pin_one));

	// ----------------------------------------------------------------
	// Clock and shared tasks
	// ----------------------------------------------------------------
	// Free-running 100 MHz clock.
	always #5 aclk = ~aclk;

	// Count one comparison; a mismatch is reported at once.
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Print the counts and the verdict, then stop.
	task automatic conclude;
		$display("Checks %0d, errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// One write; ready is sampled mid-cycle so the value seen is the one at the edge.
	task automatic write(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw_hit, w_hit, b_hit;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		b_hit = 1'b0;
		for (int n = 0; n < 50 && !b_hit; n++) begin
			@(negedge aclk);
			aw_hit = awvalid && awready;
			w_hit = wvalid && wready;
			b_hit = bvalid;
			seen = {30'h0, bresp};
			@(posedge aclk);
			if (aw_hit) awvalid <= 1'b0;
			if (w_hit) wvalid <= 1'b0;
		end
		if (!b_hit) begin
			check("write answer", 32'h1, 32'h0);
			conclude();
		end
		check("write code", {30'h0, er}, seen);
	endtask

	// One read; the data is kept in seen and compared when cmp is set.
	task automatic read(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er, input bit cmp);
		logic ar_hit, r_hit;
		logic [1:0] code;
		araddr <= a;
		arvalid <= 1'b1;
		r_hit = 1'b0;
		for (int n = 0; n < 50 && !r_hit; n++) begin
			@(negedge aclk);
			ar_hit = arvalid && arready;
			r_hit = rvalid;
			seen = rdata;
			code = rresp;
			@(posedge aclk);
			if (ar_hit) arvalid <= 1'b0;
		end
		if (!r_hit) begin
			check("read answer", 32'h1, 32'h0);
			conclude();
		end
		check("read code", {30'h0, er}, {30'h0, code});
		if (cmp) check("read data", exp, seen);
	endtask

	// Wait for one interval end under a bound, then realign to a rising edge.
	task automatic wait_done;
		logic hit;
		hit = 1'b0;
		for (int n = 0; n < 400 && !hit; n++) begin
			@(negedge aclk);
			hit = interval_done;
		end
		@(posedge aclk);
		if (!hit) begin
			check("interval end", 32'h1, 32'h0);
			conclude();
		end
	endtask

	// Rising edges on the auxiliary clock (src 1) or from the peer (src 2).
	task automatic pulses(input int src, input int n);
		repeat (n) begin
			if (src == 1) aux_clock <= 1'b1;
			else peer_go <= 1'b1;
			peer_len <= 8'h2;
			@(posedge aclk);
			aux_clock <= 1'b0;
			peer_go <= 1'b0;
			repeat (5) @(posedge aclk);
		end
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		{aclk, aresetn, aux_clock, peer_go, peer_len, awvalid, wvalid, arvalid} = '0;
		{awaddr, araddr, wdata, n_errors, total_checks} = '0;
		ce = 1'b1;
		wstrb = 4'hf;
		bready = 1'b1;
		rready = 1'b1;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		read(A_CTL, 32'h0, RESP_OKAY, 1);
		read(A_PRE, 32'h0, RESP_OKAY, 1);
		read(A_CNT, 32'h0, RESP_OKAY, 1);
		write(A_CTL, 32'h40, RESP_OKAY);
		read(A_CTL, 32'h0, RESP_OKAY, 1);
		write(12'h000, 32'h5, RESP_SLVERR);
		read(12'h000, 32'h0, RESP_SLVERR, 1);
		// A counter write loads the preload, whatever data it carries.
		write(A_PRE, 32'hfc, RESP_OKAY);
		read(A_PRE, 32'hfc, RESP_OKAY, 1);
		write(A_CNT, 32'h55, RESP_OKAY);
		read(A_CNT, 32'hfc, RESP_OKAY, 1);
		write(A_PRE, 32'h10, RESP_OKAY);
		read(A_CNT, 32'hfc, RESP_OKAY, 1);
		// Main clock runs into the wrap; the transmit bit reaches pin two.
		write(A_CTL, 32'h34, RESP_OKAY);
		wait_done();
		check("pin two", 32'h1, {31'h0, pin_two});
		check("pin two drive", 32'h1, {31'h0, pin_two_oe});
		write(A_CTL, 32'h30, RESP_OKAY);
		read(A_CNT, 32'h0, RESP_OKAY, 0);
		held = seen;
		read(A_CNT, held, RESP_OKAY, 1);
		// Gated source: a low pin blocks the main clock.
		write(A_CNT, 32'h0, RESP_OKAY);
		pulses(2, 0);
		peer_len <= 8'd20;
		peer_go <= 1'b1;
		@(posedge aclk);
		peer_go <= 1'b0;
		write(A_CTL, 32'h37, RESP_OKAY);
		read(A_CNT, 32'h10, RESP_OKAY, 1);
		write(A_CTL, 32'h30, RESP_OKAY);
		// Auxiliary clock and pin source: three rising edges, three counts.
		for (int s = 1; s < 3; s++) begin
			write(A_CNT, 32'h0, RESP_OKAY);
			write(A_CTL, 32'h34 | 32'(s), RESP_OKAY);
			pulses(s, 3);
			write(A_CTL, 32'h30 | 32'(s), RESP_OKAY);
			read(A_CNT, 32'h13, RESP_OKAY, 1);
		end
		// Start detection waits; the first interval samples the start bit.
		write(A_PRE, 32'hf0, RESP_OKAY);
		write(A_CNT, 32'h0, RESP_OKAY);
		write(A_CTL, 32'h8c, RESP_OKAY);
		read(A_CNT, 32'hf0, RESP_OKAY, 1);
		peer_len <= 8'd40;
		peer_go <= 1'b1;
		@(posedge aclk);
		peer_go <= 1'b0;
		for (int i = 0; i < 8; i++) wait_done();
		check("pin two", 32'h0, {31'h0, pin_two});
		read(A_CTL, 32'hcc, RESP_OKAY, 1);
		// Stop capture, then drain the full queue until it reports empty.
		write(A_CTL, 32'h0, RESP_OKAY);
		for (int i = 0; i < 9; i++) read(A_Q, i == 0 ? 32'h2 : (i < 8 ? 32'h3 : 32'h0), RESP_OKAY, 1);
		conclude();
	end
endmodule
`default_nettype wire
